// >>> pkg/tsi_cfg.svh
// Offsets, field positions, reset values and counts of the tick and shared interrupt block
`ifndef TSI_CFG_SVH
`define TSI_CFG_SVH

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define TSI_ADDR_W          12
`define TSI_OFS_TICK_CTRL   12'h000
`define TSI_OFS_IRQ_EN      12'h004
`define TSI_OFS_FLAGS       12'h008
`define TSI_OFS_MASK        12'h00c

// ----------------------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------------------
`define TSI_TICK_CTRL_RST   8'h37
`define TSI_TICK_CTRL_WMSK  8'hf7
`define TSI_EN_RST          6'h00
`define TSI_FLAG_RST        5'h00
`define TSI_MASK_RST        5'h00
`define TSI_RDATA_ZERO      32'h0000_0000

// ----------------------------------------------------------------------------
// Tick control fields
// ----------------------------------------------------------------------------
`define TSI_BIT_TICK_ON     7
`define TSI_BIT_CLK_SEL     6
`define TSI_T1_SEL_HI       5
`define TSI_T1_SEL_LO       4
`define TSI_T0_SEL_HI       2
`define TSI_T0_SEL_LO       0
`define TSI_T0_EXP_BASE     4'h8
`define TSI_T1_EXP_BASE     4'hc

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define TSI_PRE_LAST        2'h3
`define TSI_PRE_ZERO        2'h0
`define TSI_PRE_STEP        2'h1

`endif

// >>> pkg/tsi_pkg.sv
// Types shared by the tick and shared interrupt block
`default_nettype none
package tsi_pkg;

  // Request flags, also the layout of the flag and mask registers
  typedef struct packed {
    logic nvm_write_done_flag;
    logic tick1_req_flag;
    logic tick0_req_flag;
    logic combined1_req_flag;
    logic combined0_req_flag;
  } tsi_flags_t;

  // Enable register layout
  typedef struct packed {
    logic nvm_write_done_en;
    logic combined1_irq_en;
    logic combined0_irq_en;
    logic tick1_irq_en;
    logic tick0_irq_en;
    logic global_irq_en;
  } tsi_en_t;

  // Vector identities, in falling priority
  typedef enum logic [2:0] {
    TSI_VEC_COMB0 = 3'h0,
    TSI_VEC_COMB1 = 3'h1,
    TSI_VEC_TICK0 = 3'h2,
    TSI_VEC_TICK1 = 3'h3,
    TSI_VEC_NVM   = 3'h4
  } tsi_vec_t;

endpackage
`default_nettype wire

// >>> rtl/tsi_tick_div.sv
// Power-of-two tick divider with selectable overflow point
`timescale 1ns/1ps
`default_nettype none
`include "tsi_cfg.svh"
module tsi_tick_div #(
  parameter int CNT_W = 15,
  parameter int EXP_W = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             on,
  input  wire logic             step,
  input  wire logic [EXP_W-1:0] expo,
  output var  logic             ovf
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] mask;
  logic             ovf_ff;

  // Low-order ones up to the selected exponent
  function automatic logic [CNT_W-1:0] low_ones(input logic [EXP_W-1:0] e);
    low_ones = CNT_W'((32'h1 << e) - 32'h1);
  endfunction

  assign mask = low_ones(expo);
  assign ovf  = ovf_ff;

  // Counter held at zero while off so the first period is full length
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_ff <= '0;
    else if (!on)
      cnt_ff <= '0;
    else if (step)
      cnt_ff <= cnt_ff + CNT_W'(1);
  end

  // Overflow pulse when every selected bit is about to wrap
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ovf_ff <= 1'b0;
    else
      ovf_ff <= on && step && ((cnt_ff & mask) == mask);
  end

  period_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
    ovf_ff |-> ((cnt_ff & $past(mask)) == '0)) else $error("Divider did not wrap at overflow");

endmodule
`default_nettype wire

// >>> rtl/tsi_top.sv
// Tick generators, combined and write-done interrupt sources with APB registers
//
// Overview of operation
// - Divider overflow sets that tick's request flag.
// - Tick vectors only with global, own enable, stack free.
// - Tick service clears its flag and global enable.
// - Clock select: zero aux tick, one sysclk/4.
// - Tick1 period 2^12..2^15 from bits 5:4.
// - Tick0 period power of two from bits 2:0.
// - Tick periods depend only on clock and setting.
// - Two combined interrupts built from timer compares.
// - Any member request sets combined flag.
// - Combined vectors when enabled, stack free, requested.
// - Combined service clears only its flag, global.
// - Write-done flag set when memory write ends.
// - Write-done vectors with global, own enable, stack free.
// - Write-done service clears its flag and global.
// - Global enable low blocks all vectoring; flags record.
// - Any flag rising wakes device, enables ignored.
// - Return-from-interrupt sets global; plain return does not.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tsi_cfg.svh"
module tsi_top #(
  parameter int MEMB_N = 4,
  parameter int CNT_W  = 15
) (
  input  wire logic                   CLK,
  input  wire logic                   RST_B,
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [`TSI_ADDR_W-1:0] PADDR,
  input  wire logic [31:0]            PWDATA,
  output var  logic [31:0]            PRDATA,
  output var  logic                   PREADY,
  output var  logic                   PSLVERR,
  input  wire logic                   TICK_AUX,
  input  wire logic [MEMB_N-1:0]      COMB0_SRC,
  input  wire logic [MEMB_N-1:0]      COMB1_SRC,
  input  wire logic                   NVM_WRITE_DONE,
  input  wire logic                   STACK_FULL,
  input  wire logic                   IRQ_ACK,
  input  wire logic                   RETURN_FROM_IRQ,
  output var  logic                   VEC_REQ,
  output var  logic [2:0]             VEC_ID,
  output var  logic                   WAKE,
  output var  logic                   IRQ
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [7:0]           tick_ctrl_ff;
  tsi_pkg::tsi_en_t     en_ff;
  tsi_pkg::tsi_flags_t  flags_ff;
  tsi_pkg::tsi_flags_t  nxt_flags;
  tsi_pkg::tsi_flags_t  mask_ff;
  tsi_pkg::tsi_flags_t  pend;
  tsi_pkg::tsi_flags_t  set_ev;
  tsi_pkg::tsi_flags_t  clr_sw;
  tsi_pkg::tsi_flags_t  clr_ack;
  logic [1:0]           pre_ff;
  logic                 aux_prev_ff;
  logic                 base_tick;
  logic                 tick_gen_on;
  logic                 tick_clk_sel;
  logic [3:0]           t0_exp;
  logic [3:0]           t1_exp;
  logic                 ovf0;
  logic                 ovf1;
  logic [MEMB_N-1:0]    comb0_prev_ff;
  logic [MEMB_N-1:0]    comb1_prev_ff;
  logic                 acc_wr;
  logic                 setup;
  logic                 hit;
  logic [31:0]          rd_mux;
  logic                 vec_req_ff;
  tsi_pkg::tsi_vec_t    vec_id_ff;
  tsi_pkg::tsi_vec_t    nxt_vec_id;
  logic                 take_ack;
  logic [31:0]          prdata_ff;
  logic                 pready_ff;
  logic                 pslverr_ff;
  logic                 wake_ff;
  logic                 irq_ff;

  // Any bit rising between two samples
  function automatic logic any_rise(input logic [MEMB_N-1:0] now, input logic [MEMB_N-1:0] was);
    any_rise = |(now & ~was);
  endfunction

  // Highest-priority pending source
  function automatic tsi_pkg::tsi_vec_t pick(input tsi_pkg::tsi_flags_t p);
    if (p.combined0_req_flag)
      pick = tsi_pkg::TSI_VEC_COMB0;
    else if (p.combined1_req_flag)
      pick = tsi_pkg::TSI_VEC_COMB1;
    else if (p.tick0_req_flag)
      pick = tsi_pkg::TSI_VEC_TICK0;
    else if (p.tick1_req_flag)
      pick = tsi_pkg::TSI_VEC_TICK1;
    else
      pick = tsi_pkg::TSI_VEC_NVM;
  endfunction

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  assign setup  = PSEL && !PENABLE;
  assign acc_wr = PSEL && PENABLE && PWRITE && pready_ff;
  assign hit    = (PADDR == `TSI_OFS_TICK_CTRL) || (PADDR == `TSI_OFS_IRQ_EN) ||
                  (PADDR == `TSI_OFS_FLAGS) || (PADDR == `TSI_OFS_MASK);

  // Read mux; unused upper bits read zero
  always_comb
  begin
    rd_mux = `TSI_RDATA_ZERO;
    case (PADDR)
      `TSI_OFS_TICK_CTRL: rd_mux[7:0] = tick_ctrl_ff & `TSI_TICK_CTRL_WMSK;
      `TSI_OFS_IRQ_EN:    rd_mux[5:0] = en_ff;
      `TSI_OFS_FLAGS:     rd_mux[4:0] = flags_ff;
      `TSI_OFS_MASK:      rd_mux[4:0] = mask_ff;
      default:            rd_mux      = `TSI_RDATA_ZERO;
    endcase
  end

  // Zero wait states: ready rises for the access cycle that follows setup
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= `TSI_RDATA_ZERO;
    end
    else
    begin
      pready_ff  <= setup;
      pslverr_ff <= setup && !hit;
      if (setup && !PWRITE)
        prdata_ff <= rd_mux;
    end
  end

  // Tick control register
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      tick_ctrl_ff <= `TSI_TICK_CTRL_RST;
    else if (acc_wr && PADDR == `TSI_OFS_TICK_CTRL)
      tick_ctrl_ff <= PWDATA[7:0] & `TSI_TICK_CTRL_WMSK;
  end

  // Mask register for the level interrupt line
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      mask_ff <= `TSI_MASK_RST;
    else if (acc_wr && PADDR == `TSI_OFS_MASK)
      mask_ff <= PWDATA[4:0];
  end

  // --------------------------------------------------------------------------
  // Tick generators
  // --------------------------------------------------------------------------
  assign tick_gen_on  = tick_ctrl_ff[`TSI_BIT_TICK_ON];
  assign tick_clk_sel = tick_ctrl_ff[`TSI_BIT_CLK_SEL];
  assign t0_exp = `TSI_T0_EXP_BASE + {1'b0, tick_ctrl_ff[`TSI_T0_SEL_HI:`TSI_T0_SEL_LO]};
  assign t1_exp = `TSI_T1_EXP_BASE + {2'b00, tick_ctrl_ff[`TSI_T1_SEL_HI:`TSI_T1_SEL_LO]};

  // Divide-by-four prescaler runs free so the period is program independent
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pre_ff      <= `TSI_PRE_ZERO;
      aux_prev_ff <= 1'b0;
    end
    else
    begin
      pre_ff      <= pre_ff + `TSI_PRE_STEP;
      aux_prev_ff <= TICK_AUX;
    end
  end

  // Aux tick clock is sampled, so it must stay below half the system clock
  assign base_tick = tick_clk_sel ? (pre_ff == `TSI_PRE_LAST) : (TICK_AUX && !aux_prev_ff);

  tsi_tick_div #(
    .CNT_W (CNT_W),
    .EXP_W (4)
  ) u_div0 (
    .clk   (CLK),
    .rst_b (RST_B),
    .on    (tick_gen_on),
    .step  (base_tick),
    .expo  (t0_exp),
    .ovf   (ovf0)
  );

  tsi_tick_div #(
    .CNT_W (CNT_W),
    .EXP_W (4)
  ) u_div1 (
    .clk   (CLK),
    .rst_b (RST_B),
    .on    (tick_gen_on),
    .step  (base_tick),
    .expo  (t1_exp),
    .ovf   (ovf1)
  );

  // --------------------------------------------------------------------------
  // Request flags
  // --------------------------------------------------------------------------
  // Member sources are levels owned by the timer; only their rising edge counts
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      comb0_prev_ff <= '0;
      comb1_prev_ff <= '0;
    end
    else
    begin
      comb0_prev_ff <= COMB0_SRC;
      comb1_prev_ff <= COMB1_SRC;
    end
  end

  // Event, software clear and service clear terms
  always_comb
  begin
    set_ev.combined0_req_flag  = any_rise(COMB0_SRC, comb0_prev_ff);
    set_ev.combined1_req_flag  = any_rise(COMB1_SRC, comb1_prev_ff);
    set_ev.tick0_req_flag      = ovf0 && tick_gen_on;
    set_ev.tick1_req_flag      = ovf1 && tick_gen_on;
    set_ev.nvm_write_done_flag = NVM_WRITE_DONE;
    clr_sw  = (acc_wr && PADDR == `TSI_OFS_FLAGS) ? tsi_pkg::tsi_flags_t'(PWDATA[4:0]) : '0;
    clr_ack = '0;
    if (take_ack)
    begin
      case (vec_id_ff)
        tsi_pkg::TSI_VEC_COMB0: clr_ack.combined0_req_flag  = 1'b1;
        tsi_pkg::TSI_VEC_COMB1: clr_ack.combined1_req_flag  = 1'b1;
        tsi_pkg::TSI_VEC_TICK0: clr_ack.tick0_req_flag      = 1'b1;
        tsi_pkg::TSI_VEC_TICK1: clr_ack.tick1_req_flag      = 1'b1;
        tsi_pkg::TSI_VEC_NVM:   clr_ack.nvm_write_done_flag = 1'b1;
        default:                clr_ack                     = '0;
      endcase
    end
    nxt_flags = (flags_ff & ~clr_sw & ~clr_ack) | set_ev; // an event beats a clear in the same cycle
  end

  // Flags record events whatever the enables say
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      flags_ff <= `TSI_FLAG_RST;
    else
      flags_ff <= nxt_flags;
  end

  // --------------------------------------------------------------------------
  // Enables and global enable
  // --------------------------------------------------------------------------
  assign take_ack = IRQ_ACK && vec_req_ff;

  // Service clears global enable; return-from-interrupt sets it
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      en_ff <= `TSI_EN_RST;
    else
    begin
      if (acc_wr && PADDR == `TSI_OFS_IRQ_EN)
        en_ff <= PWDATA[5:0];
      if (RETURN_FROM_IRQ)
        en_ff.global_irq_en <= 1'b1;
      if (take_ack)
        en_ff.global_irq_en <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Vector request to the sequencer
  // --------------------------------------------------------------------------
  always_comb
  begin
    pend.combined0_req_flag  = flags_ff.combined0_req_flag && en_ff.combined0_irq_en;
    pend.combined1_req_flag  = flags_ff.combined1_req_flag && en_ff.combined1_irq_en;
    pend.tick0_req_flag      = flags_ff.tick0_req_flag && en_ff.tick0_irq_en;
    pend.tick1_req_flag      = flags_ff.tick1_req_flag && en_ff.tick1_irq_en;
    pend.nvm_write_done_flag = flags_ff.nvm_write_done_flag && en_ff.nvm_write_done_en;
    nxt_vec_id = pick(pend);
  end

  // A full stack or cleared global enable holds every request off
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      vec_req_ff <= 1'b0;
      vec_id_ff  <= tsi_pkg::TSI_VEC_COMB0;
    end
    else
    begin
      vec_req_ff <= en_ff.global_irq_en && !STACK_FULL && (|pend) && !take_ack;
      vec_id_ff  <= nxt_vec_id;
    end
  end

  // --------------------------------------------------------------------------
  // Wake and interrupt line
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      wake_ff <= 1'b0;
      irq_ff  <= 1'b0;
    end
    else
    begin
      wake_ff <= |(nxt_flags & ~flags_ff);
      irq_ff  <= |(nxt_flags & mask_ff);
    end
  end

  assign PRDATA  = prdata_ff;
  assign PREADY  = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign VEC_REQ = vec_req_ff;
  assign VEC_ID  = vec_id_ff;
  assign WAKE    = wake_ff;
  assign IRQ     = irq_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  tick_flag_set_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (ovf0 && tick_gen_on) |=> flags_ff.tick0_req_flag) else $error("Tick0 overflow lost");
  vec_gate_a: assert property (@(posedge CLK) disable iff (!RST_B)
    VEC_REQ |-> $past(en_ff.global_irq_en && !STACK_FULL)) else $error("Vector without enable");
  ack_clears_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (take_ack && vec_id_ff == tsi_pkg::TSI_VEC_TICK0 && !set_ev.tick0_req_flag)
    |=> !flags_ff.tick0_req_flag && !en_ff.global_irq_en && !VEC_REQ) else $error("Service clear missed");
  presc_sel_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (tick_clk_sel && base_tick ##1 tick_clk_sel) |-> !base_tick ##1 (!tick_clk_sel || !base_tick))
    else $error("Sysclk/4 too fast");
  t1_period_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (ovf1 && $past(t0_exp <= t1_exp)) |-> ovf0) else $error("Tick1 ratio out of range");
  comb_set_a: assert property (@(posedge CLK) disable iff (!RST_B)
    any_rise(COMB1_SRC, comb1_prev_ff) |=> flags_ff.combined1_req_flag) else $error("Member rise lost");
  nvm_set_a: assert property (@(posedge CLK) disable iff (!RST_B)
    NVM_WRITE_DONE |=> flags_ff.nvm_write_done_flag ##1 1'b1) else $error("Write done lost");
  return_from_irq_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (RETURN_FROM_IRQ && !take_ack) |=> en_ff.global_irq_en) else $error("Return did not enable");
  wake_a: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(flags_ff.tick1_req_flag) |-> WAKE) else $error("No wake on flag rise");
  tick_off_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (!tick_gen_on ##1 !tick_gen_on) |-> !ovf0 && !ovf1) else $error("Divider ran while off");

endmodule
`default_nettype wire

// >>> verif/tsi_seq_model.sv
// Model of the program sequencer and return stack that service vector requests
`timescale 1ns/1ps
`default_nettype none
module tsi_seq_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       vec_req,
  input  wire logic [2:0] vec_id,
  input  wire logic       ack_on,
  input  wire logic       return_from_irq_on,
  input  wire logic       full_cmd,
  input  wire logic [3:0] ack_dly,
  output var  logic       irq_ack,
  output var  logic       ret_irq,
  output var  logic       stack_full,
  output var  logic [2:0] last_id,
  output var  logic [7:0] ack_cnt
);
  logic       ack_ff;
  logic [3:0] wait_ff;
  logic [2:0] ret_ff;
  logic [2:0] id_ff;
  logic [7:0] cnt_ff;

  // Stack depth is only a level here; the bench decides when it is full
  assign stack_full = full_cmd;
  assign irq_ack    = ack_ff;
  assign ret_irq    = (ret_ff == 3'h1);
  assign last_id    = id_ff;
  assign ack_cnt    = cnt_ff;

  // Service after a programmable wait, so both prompt and slow answers occur
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_ff  <= 1'b0;
      wait_ff <= 4'h0;
      ret_ff  <= 3'h0;
      id_ff   <= 3'h0;
      cnt_ff  <= 8'h00;
    end
    else
    begin
      ack_ff <= 1'b0;
      // An ack only counts at an edge where the request still stands
      if (ack_ff && vec_req)
      begin
        id_ff  <= vec_id;
        cnt_ff <= cnt_ff + 8'h01;
        ret_ff <= return_from_irq_on ? 3'h4 : 3'h0;
      end
      else if (ret_ff != 3'h0)
        ret_ff <= ret_ff - 3'h1;
      if (!ack_ff && vec_req && ack_on)
      begin
        if (wait_ff >= ack_dly)
        begin
          ack_ff  <= 1'b1;
          wait_ff <= 4'h0;
        end
        else
          wait_ff <= wait_ff + 4'h1;
      end
      else
        wait_ff <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// >>> verif/tick_and_shared_irq_sources_test.sv
// Self-checking bench for the tick and shared interrupt block
`timescale 1ns/1ps
`default_nettype none
module tick_and_shared_irq_sources_test;
  logic        clk, rst_b, psel, penable, pwrite, nvm_done, tick_aux;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, vec_req, wake, irq, irq_ack, ret_irq, stack_full;
  logic [3:0]  comb0, comb1, ack_dly;
  logic [2:0]  vec_id, last_id;
  logic [7:0]  ack_cnt;
  logic        ack_on, return_from_irq_on, full_cmd;
  logic [1:0]  aux_ff;
  int          fails, n_checks, cyc, wakes;

  tsi_top #(.MEMB_N(4), .CNT_W(15)) dut (
    .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TICK_AUX(tick_aux), .COMB0_SRC(comb0), .COMB1_SRC(comb1), .NVM_WRITE_DONE(nvm_done),
    .STACK_FULL(stack_full), .IRQ_ACK(irq_ack), .RETURN_FROM_IRQ(ret_irq),
    .VEC_REQ(vec_req), .VEC_ID(vec_id), .WAKE(wake), .IRQ(irq));

  tsi_seq_model seq (
    .clk(clk), .rst_b(rst_b), .vec_req(vec_req), .vec_id(vec_id), .ack_on(ack_on),
    .return_from_irq_on(return_from_irq_on), .full_cmd(full_cmd), .ack_dly(ack_dly), .irq_ack(irq_ack),
    .ret_irq(ret_irq), .stack_full(stack_full), .last_id(last_id), .ack_cnt(ack_cnt));

  // ------------------------------------------------------------------
  // Clock, auxiliary tick and event counters
  // ------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Aux tick runs free at a quarter of the clock, same rate as sys/4
  assign tick_aux = aux_ff[1];
  always @(posedge clk)
  begin
    cyc    <= cyc + 1;
    aux_ff <= aux_ff + 2'h1;
    if (wake === 1'b1)
      wakes <= wakes + 1;
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Ready, data and error are all taken at the rising edge that ends the access
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      chk(32'h1, 32'h0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk({31'h0, err}, 32'h0);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wait_ack(input logic [7:0] c0, input int lim);
    int n = 0;
    while (ack_cnt === c0 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= lim)
      chk(32'h1, 32'h0);
  endtask

  task automatic pulse_nvm();
    @(posedge clk);
    nvm_done <= 1'b1;
    @(posedge clk);
    nvm_done <= 1'b0;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    rdc(12'h000, 32'h37);
    rdc(12'h004, 32'h0);
    rdc(12'h008, 32'h0);
    rdc(12'h00c, 32'h0);
    apb(1'b1, 12'h010, 32'hff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    wr(12'h000, 32'h4f);
    rdc(12'h000, 32'h47);
    $display("TB: regs done");
  endtask

  task automatic t_comb();
    logic [7:0] c;
    int w;
    for (int i = 0; i < 2; i++)
    begin
      wr(12'h004, 32'h1 | (32'h8 << i));
      c = ack_cnt;
      w = wakes;
      if (i == 0)
        comb0 <= 4'h4;
      else
        comb1 <= 4'h2;
      wait_ack(c, 20);
      chk({29'h0, last_id}, 32'(i));
      chk(32'(wakes - w), 32'h1);
      rdc(12'h008, 32'h0);
      rdc(12'h004, 32'h8 << i);
      // Members stay high until software drops them
      comb0 <= 4'h0;
      comb1 <= 4'h0;
    end
    $display("TB: combined done");
  endtask

  task automatic t_nvm();
    logic [7:0] c;
    wr(12'h004, 32'h20);
    pulse_nvm();
    cycles(4);
    chk({31'h0, vec_req}, 32'h0);
    rdc(12'h008, 32'h10);
    wr(12'h00c, 32'h10);
    cycles(2);
    chk({31'h0, irq}, 32'h1);
    wr(12'h008, 32'h10);
    cycles(2);
    chk({31'h0, irq}, 32'h0);
    rdc(12'h008, 32'h0);
    full_cmd <= 1'b1;
    ack_dly  <= 4'h6;
    return_from_irq_on  <= 1'b1;
    c = ack_cnt;
    wr(12'h004, 32'h21);
    pulse_nvm();
    cycles(10);
    chk({31'h0, vec_req}, 32'h0);
    full_cmd <= 1'b0;
    wait_ack(c, 40);
    chk({29'h0, last_id}, 32'h4);
    rdc(12'h008, 32'h0);
    cycles(6);
    rdc(12'h004, 32'h21);
    ack_dly <= 4'h0;
    $display("TB: write-done done");
  endtask

  // A flag left set by service would re-vector at once and shorten the interval
  task automatic t_tick(input logic [7:0] ctrl, input logic [31:0] en, input int per,
                        input logic [2:0] id);
    logic [7:0] c;
    int t0;
    wr(12'h008, 32'h1f);
    wr(12'h004, en | 32'h1);
    c = ack_cnt;
    wr(12'h000, {24'h0, ctrl});
    wait_ack(c, 2 * per + 64);
    t0 = cyc;
    c = ack_cnt;
    wait_ack(c, per + 64);
    chk(32'(cyc - t0), 32'(per));
    chk({29'h0, last_id}, {29'h0, id});
    wr(12'h000, {24'h0, ctrl & 8'h7f});
    wr(12'h004, 32'h0);
    $display("TB: tick done");
  endtask

  task automatic t_off();
    wr(12'h000, 32'h40);
    wr(12'h008, 32'h1f);
    cycles(2200);
    rdc(12'h008, 32'h0);
    $display("TB: tick off done");
  endtask

  task automatic end_sim();
    $display("TB: checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial
  begin
    {fails, n_checks, cyc, wakes} = '0;
    {psel, penable, pwrite, nvm_done, return_from_irq_on, full_cmd} = '0;
    {paddr, pwdata, comb0, comb1, ack_dly, aux_ff} = '0;
    ack_on = 1'b1;
    rst_b  = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_comb();
    t_nvm();
    t_tick(8'hc0, 32'h2, 1024, 3'h2);
    t_tick(8'hc1, 32'h2, 2048, 3'h2);
    t_tick(8'h80, 32'h2, 1024, 3'h2);
    t_tick(8'hc0, 32'h4, 16384, 3'h3);
    t_off();
    end_sim();
  end

  // Tests need about 45k cycles; the longest tick period sets the margin
  initial
  begin
    #800000;
    fails++;
    end_sim();
  end
endmodule
`default_nettype wire
